/* hw/fpdk_map.vh */
`ifndef FPDK_MAP_VH
`define FPDK_MAP_VH
// Register offsets on the plain register port (word index = byte address).
`define FPDK_ADDR_DISP_LO   4'h0
`define FPDK_ADDR_DISP_HI   4'h1
`define FPDK_ADDR_CTRL      4'h2
`define FPDK_ADDR_LED       4'h3
`define FPDK_ADDR_KEY       4'h4
`define FPDK_ADDR_IRQ_STAT  4'h5
`define FPDK_ADDR_IRQ_EN    4'h6
`define FPDK_ADDR_IRQ_CLR   4'h7
`define FPDK_ADDR_BLANK     4'h8
// Geometry.
`define FPDK_NUM_CHARS      8
`define FPDK_DP_CHAR        1
`define FPDK_NUM_LEDS       10
// Key status field positions.
`define FPDK_KEY_VALID_BIT  4
`define FPDK_KEY_STOP_BIT   5
// Interrupt status bits.
`define FPDK_IRQ_KEY_BIT    0
`define FPDK_IRQ_STOP_BIT   1
// Reset values.
`define FPDK_RST_DATA       16'h0000
`define FPDK_RST_BLANK      8'hff
// Last count of the scan divider; each position is shown this long plus one.
`define FPDK_SCAN_LAST      10'h3ff
// Timing: contact settling time and clock rate.
`define FPDK_SETTLE_US      5000
`define FPDK_CLK_MHZ        20
`define FPDK_SETTLE_CYC     (`FPDK_SETTLE_US * `FPDK_CLK_MHZ)
`endif

/* hw/fpdk_mem.v */
`timescale 1ns/1ns
`default_nettype none
// Eight-entry by four-bit storage of display characters, registered read.
module fpdk_mem (
   input  wire       clk,
   input  wire       we,
   input  wire [2:0] waddr,
   input  wire [3:0] wdata,
   input  wire [2:0] raddr,
   output reg  [3:0] rdata
);
   reg [3:0] mem [0:7];

   // Write and registered read; contents hold until rewritten.
   always @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
   end
endmodule
`default_nettype wire

/* hw/fpdk_top.v */
`timescale 1ns/1ns
`default_nettype none
`include "fpdk_map.vh"
module fpdk_top #(
   parameter SETTLE_CYC = `FPDK_SETTLE_CYC
) (
   input  wire        clk,
   input  wire        nrst,
   input  wire [3:0]  addr,
   input  wire [15:0] wdata,
   input  wire        wr,
   input  wire        rd,
   output reg  [15:0] rdata,
   output reg  [6:0]  seg_n,
   output reg  [6:0]  seg_oe,
   output reg         dp_oe,
   output reg  [7:0]  digit_sel,
   output reg  [9:0]  led_oe,
   input  wire [3:0]  key_data_n,
   input  wire        key_ctrl_n,
   input  wire        stop_sw_n,
   output reg         irq
);
   // Reset synchroniser.
   // Assertion stays asynchronous, release waits for two clock edges.
   reg rst_s1_r;
   reg rst_n_r;
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rst_s1_r <= 1'b0;
         rst_n_r  <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_n_r  <= rst_s1_r;
      end
   end

   // Hex to seven segment, segment a in bit 0, one means lit.
   // Codes above nine show the letters A to F.
   function [6:0] fpdk_hex7;
      input [3:0] v;
      begin
         case (v)
            4'h0: fpdk_hex7 = 7'h3f;
            4'h1: fpdk_hex7 = 7'h06;
            4'h2: fpdk_hex7 = 7'h5b;
            4'h3: fpdk_hex7 = 7'h4f;
            4'h4: fpdk_hex7 = 7'h66;
            4'h5: fpdk_hex7 = 7'h6d;
            4'h6: fpdk_hex7 = 7'h7d;
            4'h7: fpdk_hex7 = 7'h07;
            4'h8: fpdk_hex7 = 7'h7f;
            4'h9: fpdk_hex7 = 7'h6f;
            4'ha: fpdk_hex7 = 7'h77;
            4'hb: fpdk_hex7 = 7'h7c;
            4'hc: fpdk_hex7 = 7'h39;
            4'hd: fpdk_hex7 = 7'h5e;
            4'he: fpdk_hex7 = 7'h79;
            default: fpdk_hex7 = 7'h71;
         endcase
      end
   endfunction

   // Software-visible registers.
   reg [31:0] latch_r;
   reg [7:0]  strobe_r;
   reg [7:0]  blank_r;
   reg        dp_r;
   reg [9:0]  led_r;
   reg [1:0]  irq_stat_r;
   reg [1:0]  irq_en_r;

   // Write decode for one register offset; shared by every register.
   function fpdk_wr_hit;
      input       w;
      input [3:0] a;
      input [3:0] target;
      begin
         fpdk_wr_hit = w && (a == target);
      end
   endfunction

   // Write hits per register; unmapped or read-only offsets hit nothing.
   wire       wr_lo  = fpdk_wr_hit(wr, addr, `FPDK_ADDR_DISP_LO);
   wire       wr_hi  = fpdk_wr_hit(wr, addr, `FPDK_ADDR_DISP_HI);
   wire       wr_ct  = fpdk_wr_hit(wr, addr, `FPDK_ADDR_CTRL);
   wire       wr_led = fpdk_wr_hit(wr, addr, `FPDK_ADDR_LED);
   wire       wr_en  = fpdk_wr_hit(wr, addr, `FPDK_ADDR_IRQ_EN);
   wire       wr_bl  = fpdk_wr_hit(wr, addr, `FPDK_ADDR_BLANK);

   // Pending positions, walked by the transfer index into storage.
   reg [2:0]  xfer_idx_r;
   reg [7:0]  xfer_pend_r;

   // Input synchronisers: three stages, change accepted on agreement.
   // The whole vector must agree, so key data and control move together.
   reg [5:0] in_s1_r;
   reg [5:0] in_s2_r;
   reg [5:0] in_s3_r;
   reg [5:0] in_clean_r;
   always @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         in_s1_r    <= 6'h3f;
         in_s2_r    <= 6'h3f;
         in_s3_r    <= 6'h3f;
         in_clean_r <= 6'h3f;
      end else begin
         in_s1_r <= {stop_sw_n, key_ctrl_n, key_data_n};
         in_s2_r <= in_s1_r;
         in_s3_r <= in_s2_r;
         if (in_s2_r == in_s3_r) begin
            in_clean_r <= in_s3_r;
         end
      end
   end

   // Settle filter: key must be stable for the contact settling time.
   // A release or a data change restarts the count; held data stay readable.
   reg [20:0] settle_cnt_r;
   reg [4:0]  key_prev_r;
   reg        key_valid_r;
   reg [3:0]  key_val_r;
   reg        stop_r;
   wire [4:0] key_now = in_clean_r[4:0];
   always @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         settle_cnt_r <= 21'h00_0000;
         key_prev_r   <= 5'h1f;
         key_valid_r  <= 1'b0;
         key_val_r    <= 4'h0;
         stop_r       <= 1'b0;
      end else begin
         key_prev_r <= key_now;
         stop_r     <= ~in_clean_r[5];
         if (key_now != key_prev_r || key_now[4]) begin
            settle_cnt_r <= 21'h00_0000;
            if (key_now[4]) begin
               key_valid_r <= 1'b0;
            end
         end else if (settle_cnt_r < SETTLE_CYC[20:0]) begin
            settle_cnt_r <= settle_cnt_r + 21'h00_0001;
         end else begin
            key_valid_r <= 1'b1;
            key_val_r   <= ~key_now[3:0];
         end
      end
   end

   // Interrupt events: new valid key, stop switch change.
   // Both detectors reset to the idle level, so reset makes no event.
   reg key_valid_d_r;
   reg stop_d_r;
   wire ev_key  = key_valid_r & ~key_valid_d_r;
   wire ev_stop = stop_r ^ stop_d_r;
   wire clr_wr  = fpdk_wr_hit(wr, addr, `FPDK_ADDR_IRQ_CLR);

   // Register writes and sticky status, set wins over clear.
   // Writes to read-only or unmapped offsets fall through untouched.
   always @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         latch_r       <= 32'h0000_0000;
         strobe_r      <= 8'h00;
         blank_r       <= `FPDK_RST_BLANK;
         dp_r          <= 1'b0;
         led_r         <= 10'h000;
         irq_stat_r    <= 2'h0;
         irq_en_r      <= 2'h0;
         key_valid_d_r <= 1'b0;
         stop_d_r      <= 1'b0;
      end else begin
         key_valid_d_r <= key_valid_r;
         stop_d_r      <= stop_r;
         strobe_r      <= 8'h00;
         if (wr_lo) begin
            latch_r[15:0] <= wdata;
         end
         if (wr_hi) begin
            latch_r[31:16] <= wdata;
         end
         if (wr_ct) begin
            strobe_r <= wdata[7:0];
            dp_r     <= wdata[8];
         end
         if (wr_bl) begin
            blank_r <= wdata[7:0];
         end
         if (wr_led) begin
            led_r <= wdata[9:0];
         end
         if (wr_en) begin
            irq_en_r <= wdata[1:0];
         end
         irq_stat_r <= (irq_stat_r & ~({2{clr_wr}} & wdata[1:0]))
                       | {ev_stop, ev_key};
      end
   end

   // Strobe transfer walks pending positions one at a time into storage.
   // A strobe that meets a busy walk merges into the pending set.
   reg        mem_we;
   reg [2:0]  scan_r;
   wire [3:0] mem_q;
   wire [7:0] pend_nxt = xfer_pend_r | strobe_r;
   always @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         xfer_pend_r <= 8'h00;
         xfer_idx_r  <= 3'h0;
      end else begin
         xfer_idx_r  <= xfer_idx_r + 3'h1;
         xfer_pend_r <= pend_nxt & ~(8'h01 << xfer_idx_r);
      end
   end
   always @* begin
      mem_we = pend_nxt[xfer_idx_r];
   end

   // Storage has no reset; the blank register hides it until software writes the blank register.
   fpdk_mem u_mem (
      .clk   (clk),
      .we    (mem_we),
      .waddr (xfer_idx_r),
      .wdata (latch_r[xfer_idx_r*4 +: 4]),
      .raddr (scan_r),
      .rdata (mem_q)
   );

   // Display scan: one position per step, digit select follows two cycles later.
   // Storage read data lag the scan index by one cycle; shown_r keeps the
   // select in step with them, so no digit shows on its neighbour.
   reg [9:0] scan_div_r;
   reg [2:0] shown_r;
   always @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         scan_div_r <= 10'h000;
         scan_r     <= 3'h0;
         shown_r    <= 3'h0;
         seg_n      <= 7'h00;
         seg_oe     <= 7'h00;
         dp_oe      <= 1'b0;
         digit_sel  <= 8'h00;
         led_oe     <= 10'h000;
         irq        <= 1'b0;
      end else begin
         scan_div_r <= scan_div_r + 10'h001;
         if (scan_div_r == `FPDK_SCAN_LAST) begin
            scan_r <= scan_r + 3'h1;
         end
         shown_r <= scan_r;
         seg_n   <= 7'h00;
         if (blank_r[shown_r]) begin
            seg_oe <= 7'h00;
            dp_oe  <= 1'b0;
         end else begin
            seg_oe <= fpdk_hex7(mem_q);
            dp_oe  <= dp_r && (shown_r == `FPDK_DP_CHAR);
         end
         digit_sel <= 8'h01 << shown_r;
         led_oe    <= led_r;
         irq       <= |(irq_stat_r & irq_en_r);
      end
   end

   // Read data one cycle after the read strobe.
   // Unmapped reads and idle cycles return zero.
   always @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         rdata <= `FPDK_RST_DATA;
      end else if (rd) begin
         case (addr)
            `FPDK_ADDR_DISP_LO:  rdata <= latch_r[15:0];
            `FPDK_ADDR_DISP_HI:  rdata <= latch_r[31:16];
            `FPDK_ADDR_CTRL:     rdata <= {7'h00, dp_r, 8'h00};
            `FPDK_ADDR_LED:      rdata <= {6'h00, led_r};
            `FPDK_ADDR_KEY:      rdata <= {10'h000, stop_r, key_valid_r,
                                           key_val_r};
            `FPDK_ADDR_IRQ_STAT: rdata <= {14'h0000, irq_stat_r};
            `FPDK_ADDR_IRQ_EN:   rdata <= {14'h0000, irq_en_r};
            `FPDK_ADDR_BLANK:    rdata <= {8'h00, blank_r};
            default:             rdata <= 16'h0000;
         endcase
      end else begin
         rdata <= 16'h0000;
      end
   end
endmodule
`default_nettype wire

/* sim/fpdk_chk.sv */
`timescale 1ns/1ns
`default_nettype none
// Watches the panel ports for bus answers, scan timing and drive levels.
module fpdk_chk #(
   parameter SETTLE_CYC = 100000
) (
   input wire logic        clk,
   input wire logic        nrst,
   input wire logic [3:0]  addr,
   input wire logic [15:0] wdata,
   input wire logic        wr,
   input wire logic        rd,
   input wire logic [15:0] rdata,
   input wire logic [6:0]  seg_n,
   input wire logic [6:0]  seg_oe,
   input wire logic        dp_oe,
   input wire logic [7:0]  digit_sel,
   input wire logic [9:0]  led_oe,
   input wire logic [3:0]  key_data_n,
   input wire logic        key_ctrl_n,
   input wire logic        stop_sw_n,
   input wire logic        irq
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);

   // Read data only appear in the cycle after a read strobe.
   rdata_idle_a: assert property (
      rdata != 16'h0000 |-> $past(rd)) else $error("stray read data");
   seg_ground_a: assert property (
      seg_n == 7'h00) else $error("segment level not ground");
   scan_hold_a: assert property (
      $changed(digit_sel) |-> $onehot0(digit_sel) ##1 $stable(digit_sel)[*8])
      else $error("scan position unstable");
   dp_pos_a: assert property (
      dp_oe |-> digit_sel == 8'h02) else $error("dp off position");
   seg_scan_a: assert property (
      seg_oe != 7'h00 |-> $past(digit_sel, 2) != 8'h00)
      else $error("segments lit without scan");
   led_write_a: assert property (
      wr && addr == 4'h3 |=> ##1 led_oe == $past(wdata[9:0], 2))
      else $error("led write lost");
   led_hold_a: assert property (
      !(wr && addr == 4'h3) |-> ##2 $stable(led_oe))
      else $error("led drifted");
   irq_fall_a: assert property (
      $fell(irq) |-> $past(wr) || $past(wr, 2) || $past(wr, 3))
      else $error("irq dropped without write");

   // Main scenarios reached.
   cover property (dp_oe);
   cover property ($rose(irq));
   cover property (rd && addr == 4'h4);
endmodule
bind fpdk_top fpdk_chk #(.SETTLE_CYC(SETTLE_CYC)) i_chk (
   .clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
   .rdata(rdata), .seg_n(seg_n), .seg_oe(seg_oe), .dp_oe(dp_oe),
   .digit_sel(digit_sel), .led_oe(led_oe), .key_data_n(key_data_n),
   .key_ctrl_n(key_ctrl_n), .stop_sw_n(stop_sw_n), .irq(irq));
`default_nettype wire

/* sim/fpdk_keypad.sv */
`timescale 1ns/1ns
`default_nettype none
// Keypad and stop switch; open contacts float to the pull-up level.
module fpdk_keypad (
   input  wire logic       clk,
   input  wire logic       press,
   input  wire logic [3:0] code,
   input  wire logic       stop_on,
   output logic [3:0]      key_data_n,
   output logic            key_ctrl_n,
   output logic            stop_sw_n
);
   logic [2:0] bounce_r = 3'h0;
   logic       press_d_r = 1'b0;
   // A fresh press chatters the valid contact for a few cycles.
   always @(posedge clk) begin
      press_d_r <= press;
      if (press && !press_d_r)
         bounce_r <= 3'h6;
      else if (bounce_r != 3'h0)
         bounce_r <= bounce_r - 3'h1;
   end
   assign key_data_n = press ? ~code : 4'hF;
   assign key_ctrl_n = !press || bounce_r[0];
   assign stop_sw_n  = !stop_on;
endmodule
`default_nettype wire

/* sim/tb_front_panel_display_keypad.sv */
`timescale 1ns/1ns
`default_nettype none
`include "fpdk_map.vh"
// Drives the panel through its register port and a keypad model.
module tb_front_panel_display_keypad;
   localparam int SETTLE = 20;
   localparam logic [111:0] SEGS = {7'h71, 7'h79, 7'h5E, 7'h39, 7'h7C,
      7'h77, 7'h6F, 7'h7F, 7'h07, 7'h7D, 7'h6D, 7'h66, 7'h4F, 7'h5B, 7'h06,
      7'h3F};
   logic        clk = 1'b0;
   logic        nrst = 1'b0;
   logic [3:0]  addr = 4'h0;
   logic [15:0] wdata = 16'h0000;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic        press = 1'b0;
   logic [3:0]  code = 4'h0;
   logic        stop_on = 1'b0;
   wire  [15:0] rdata;
   wire  [6:0]  seg_n;
   wire  [6:0]  seg_oe;
   wire         dp_oe;
   wire  [7:0]  digit_sel;
   wire  [9:0]  led_oe;
   wire  [3:0]  key_data_n;
   wire         key_ctrl_n;
   wire         stop_sw_n;
   wire         irq;
   int          err_total = 0;
   int          n_checks = 0;

   fpdk_top #(.SETTLE_CYC(SETTLE)) i_dut (.clk(clk), .nrst(nrst),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .seg_n(seg_n), .seg_oe(seg_oe), .dp_oe(dp_oe), .digit_sel(digit_sel),
      .led_oe(led_oe), .key_data_n(key_data_n), .key_ctrl_n(key_ctrl_n),
      .stop_sw_n(stop_sw_n), .irq(irq));
   fpdk_keypad i_pad (.clk(clk), .press(press), .code(code),
      .stop_on(stop_on), .key_data_n(key_data_n), .key_ctrl_n(key_ctrl_n),
      .stop_sw_n(stop_sw_n));

   // Free-running 20 MHz clock.
   always #25 clk = ~clk;

   // Comparison, verdict and bus helpers.
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish();
      if (err_total == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic give_up();
      err_total++;
      $display("[ERR] %0t wait timed out", $time);
      tally_and_finish();
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      chk(rdata, exp);
   endtask
   task automatic wait_sel(input int p);
      int i;
      for (i = 0; i < 9000 && digit_sel !== 8'(1 << p); i++) @(negedge clk);
      if (i == 9000) give_up();
      repeat (3) @(negedge clk);
   endtask
   task automatic wait_irq(input logic v, input int lim);
      int i;
      for (i = 0; i < lim && irq !== v; i++) @(negedge clk);
      if (i == lim) give_up();
   endtask

   // Reset values, LED drive, read-only and unmapped accesses.
   task automatic t_led();
      @(negedge clk);
      chk(16'(seg_oe), 16'h0000);
      rd_chk(`FPDK_ADDR_BLANK, 16'h00FF);
      rd_chk(4'hF, 16'h0000);
      wr_reg(`FPDK_ADDR_LED, 16'h02A5);
      repeat (2) @(negedge clk);
      chk(16'(led_oe), 16'h02A5);
      wr_reg(`FPDK_ADDR_KEY, 16'hFFFF);
      wr_reg(4'hE, 16'hFFFF);
      rd_chk(`FPDK_ADDR_LED, 16'h02A5);
   endtask

   // Latch eight digits, strobe them all with the point, check each.
   task automatic t_digits(input logic [31:0] v);
      wr_reg(`FPDK_ADDR_DISP_LO, v[15:0]);
      wr_reg(`FPDK_ADDR_DISP_HI, v[31:16]);
      wr_reg(`FPDK_ADDR_CTRL, 16'h01FF);
      wr_reg(`FPDK_ADDR_BLANK, 16'h0000);
      repeat (10) @(negedge clk);
      for (int p = 0; p < 8; p++) begin
         wait_sel(p);
         chk(16'(seg_oe), 16'(SEGS[v[p*4 +: 4]*7 +: 7]));
         chk(16'(dp_oe), 16'(p == 1));
      end
   endtask

   // Latch without strobe keeps the old digit; blanking darkens one.
   task automatic t_blank();
      wr_reg(`FPDK_ADDR_DISP_LO, 16'h0005);
      wait_sel(0);
      chk(16'(seg_oe), 16'h007F);
      wr_reg(`FPDK_ADDR_BLANK, 16'h0002);
      wait_sel(1);
      chk(16'(seg_oe), 16'h0000);
      chk(16'(dp_oe), 16'h0000);
      rd_chk(`FPDK_ADDR_CTRL, 16'h0100);
      rd_chk(`FPDK_ADDR_DISP_LO, 16'h0005);
   endtask

   // Bouncing key, settle filter, interrupt clear, mask and release.
   task automatic t_key();
      wr_reg(`FPDK_ADDR_IRQ_EN, 16'h0003);
      wr_reg(`FPDK_ADDR_IRQ_CLR, 16'h0003);
      code <= 4'h9;
      press <= 1'b1;
      repeat (SETTLE) @(negedge clk);
      chk(16'(irq), 16'h0000);
      wait_irq(1'b1, SETTLE + 40);
      rd_chk(`FPDK_ADDR_KEY, 16'h0019);
      rd_chk(`FPDK_ADDR_IRQ_STAT, 16'h0001);
      wr_reg(`FPDK_ADDR_IRQ_EN, 16'h0002);
      wait_irq(1'b0, 8);
      wr_reg(`FPDK_ADDR_IRQ_CLR, 16'h0001);
      wr_reg(`FPDK_ADDR_IRQ_EN, 16'h0003);
      press <= 1'b0;
      repeat (10) @(negedge clk);
      rd_chk(`FPDK_ADDR_KEY, 16'h0009);
      chk(16'(irq), 16'h0000);
   endtask

   // Stop switch reaches the host and raises its own event.
   task automatic t_stop();
      stop_on <= 1'b1;
      wait_irq(1'b1, SETTLE + 40);
      rd_chk(`FPDK_ADDR_KEY, 16'h0029);
      rd_chk(`FPDK_ADDR_IRQ_STAT, 16'h0002);
      rd_chk(`FPDK_ADDR_IRQ_EN, 16'h0003);
      wr_reg(`FPDK_ADDR_IRQ_CLR, 16'h0002);
      wait_irq(1'b0, 8);
   endtask

   // Reset, then the scenarios in turn.
   initial begin
      repeat (16) @(posedge clk);
      nrst <= 1'b1;
      repeat (4) @(posedge clk);
      t_led();
      t_digits(32'h7654_3210);
      t_digits(32'hFEDC_BA98);
      t_blank();
      t_key();
      t_stop();
      tally_and_finish();
   end
endmodule
`default_nettype wire
